// ==== rtl/mexp_bus.sv ====
// Memory expansion and general port logic: ports D, F, C and bus cycle engine
`timescale 1ns/100ps
`default_nettype none
module mexp_bus
  import mexp_pkg::*;
#(
  parameter int unsigned ADDR_HOLD = mexp_pkg::ADDR_HOLD_CYC,
  parameter int unsigned ALE_HIGH  = mexp_pkg::ALE_HIGH_CYC,
  parameter int unsigned STB_LOW   = mexp_pkg::STB_LOW_CYC,
  parameter int unsigned FETCH_LOW = mexp_pkg::FETCH_LOW_CYC,
  parameter int unsigned WR_HOLD   = mexp_pkg::WR_HOLD_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // Core access request
  input  wire logic        acc_req,
  input  wire logic        acc_write,
  input  wire logic        acc_fetch,
  input  wire logic        acc_io,
  input  wire logic [15:0] acc_addr,
  input  wire logic [7:0]  acc_wdata,
  output logic             acc_done,
  output logic             acc_ext,
  output logic [7:0]       acc_rdata,
  // Port configuration from the core
  input  wire logic        cfg_we,
  input  wire logic        bus_en_in,
  input  wire logic        addr_data_dir_in,
  input  wire logic [7:0]  high_dir_in,
  input  wire logic [7:0]  alt_dir_in,
  input  wire logic [7:0]  alt_func_in,
  input  wire logic        port_we,
  input  wire logic [7:0]  addr_data_out_in,
  input  wire logic [7:0]  high_out_in,
  input  wire logic [7:0]  alt_out_in,
  input  wire logic [7:0]  alt_periph_out,
  output logic [7:0]       addr_data_rd,
  output logic [7:0]       high_rd,
  output logic [7:0]       alt_rd,
  output logic [2:0]       exp_mode,
  // Pins
  input  wire logic [7:0]  addr_data_lines_i,
  output logic [7:0]       addr_data_lines_o,
  output logic [7:0]       addr_data_lines_oe,
  input  wire logic [7:0]  high_address_lines_i,
  output logic [7:0]       high_address_lines_o,
  output logic [7:0]       high_address_lines_oe,
  input  wire logic [7:0]  alt_function_lines_i,
  output logic [7:0]       alt_function_lines_o,
  output logic [7:0]       alt_function_lines_oe,
  input  wire logic        mode_select_hi_i,
  output logic             mode_select_hi_o,
  output logic             mode_select_hi_oe,
  input  wire logic        mode_select_lo_i,
  output logic             mode_select_lo_o,
  output logic             mode_select_lo_oe,
  output logic             ale,
  output logic             rd_n,
  output logic             wr_n
);
  import mexp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [2:0] mode_of(input logic en, input logic [1:0] code);
    unique case (code)
      2'b00:   mode_of = MODE_256;
      2'b01:   mode_of = MODE_4K;
      2'b10:   mode_of = MODE_16K;
      default: mode_of = MODE_60K;
    endcase
    if (!en) begin
      mode_of = MODE_NONE;
    end
  endfunction : mode_of

  function automatic logic [7:0] hi_mask(input logic [2:0] m);
    case (m)
      MODE_4K:  hi_mask = HI_MASK_4K;
      MODE_16K: hi_mask = HI_MASK_16K;
      MODE_60K: hi_mask = HI_MASK_60K;
      default:  hi_mask = 8'h00;
    endcase
  endfunction : hi_mask

  // Window opens just above on-chip ROM and spans what the mode's address lines can name
  function automatic logic in_range(input logic [2:0] m, input logic [15:0] a);
    logic [15:0] top;
    top = {hi_mask(m), 8'hFF};
    in_range = (m != MODE_NONE) && (((a - (ROM_LAST + 16'h0001)) & ~top) == 16'h0000);
  endfunction : in_range

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [7:0] ad_s;
  logic [7:0] hi_s;
  logic [7:0] alt_s;
  logic [1:0] mode_s;

  mexp_sync #(.WIDTH(8)) u_sync_ad (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in (addr_data_lines_i),
    .sync_out (ad_s)
  );
  mexp_sync #(.WIDTH(8)) u_sync_hi (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in (high_address_lines_i),
    .sync_out (hi_s)
  );
  mexp_sync #(.WIDTH(8)) u_sync_alt (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in (alt_function_lines_i),
    .sync_out (alt_s)
  );
  mexp_sync #(.WIDTH(2)) u_sync_mode (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in ({mode_select_hi_i, mode_select_lo_i}),
    .sync_out (mode_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    mexp_state_e      st;
    logic [CNT_W-1:0] cnt;
    logic             strap_done;
    logic [1:0]       strap;
    logic [1:0]       strap_age;
    logic [2:0]       mode;
    logic             bus_en;
    logic             ad_dir;
    logic [7:0]       hi_dir;
    logic [7:0]       alt_dir;
    logic [7:0]       alt_func;
    logic [7:0]       ad_out;
    logic [7:0]       hi_out;
    logic [7:0]       alt_out;
    logic             wr;
    logic             fetch;
    logic             io;
    logic [15:0]      addr;
    logic [7:0]       wdata;
    logic [7:0]       rdata;
    logic             done;
    logic             ext;
    logic [7:0]       ad_o;
    logic [7:0]       ad_oe;
    logic [7:0]       hi_o;
    logic [7:0]       hi_oe;
    logic [7:0]       alt_o;
    logic [7:0]       alt_oe;
    logic [7:0]       ad_rd;
    logic [7:0]       hi_rd;
    logic [7:0]       alt_rd;
    logic             ale;
    logic             rd_n;
    logic             wr_n;
    logic             m1;
    logic             iom;
  } mexp_state_s;

  mexp_state_s s_reg;
  mexp_state_s s_next;
  logic [2:0]  mode_eff;

  // Mode from the caught strap, active only once software enables the bus
  assign mode_eff = mode_of(s_reg.bus_en, s_reg.strap);

  always_comb begin
    logic [7:0] hm;
    logic       ext_ok;
    hm     = hi_mask(mode_eff);
    ext_ok = acc_addr > ROM_LAST && acc_addr < RAM_FIRST && in_range(mode_eff, acc_addr);
    s_next = s_reg;
    s_next.done = 1'b0;
    // Strap is caught on the third edge after reset, once the synchroniser holds the pins
    if (!s_reg.strap_done) begin
      if (s_reg.strap_age == 2'h2) begin
        s_next.strap      = mode_s;
        s_next.strap_done = 1'b1;
      end else begin
        s_next.strap_age = s_reg.strap_age + 2'h1;
      end
    end
    if (cfg_we) begin
      s_next.bus_en   = bus_en_in;
      s_next.ad_dir   = addr_data_dir_in;
      s_next.hi_dir   = high_dir_in;
      s_next.alt_dir  = alt_dir_in;
      s_next.alt_func = alt_func_in;
    end
    if (port_we) begin
      s_next.ad_out  = addr_data_out_in;
      s_next.hi_out  = high_out_in;
      s_next.alt_out = alt_out_in;
    end
    s_next.cnt = s_reg.cnt - 1'b1;
    unique case (s_reg.st)
      MEXP_IDLE: begin
        s_next.cnt = s_reg.cnt;
        if (acc_req && ext_ok) begin
          s_next.st    = MEXP_ADDR;
          s_next.wr    = acc_write;
          s_next.fetch = acc_fetch && !acc_write;
          s_next.io    = acc_io;
          s_next.addr  = acc_addr;
          s_next.wdata = acc_wdata;
          s_next.ale   = 1'b1;
          s_next.cnt   = CNT_W'(ALE_HIGH - 1);
          s_next.m1    = acc_fetch && !acc_write;
          s_next.iom   = acc_io;
        end else if (acc_req) begin
          s_next.done = 1'b1;  // Internal target, answered at once
          s_next.ext  = 1'b0;
        end
      end
      MEXP_ADDR: begin
        if (s_reg.cnt == '0) begin
          s_next.ale = 1'b0;
          s_next.st  = MEXP_HOLD;
          s_next.cnt = CNT_W'(ADDR_HOLD - 1);
        end
      end
      MEXP_HOLD: begin
        if (s_reg.cnt == '0) begin
          s_next.st = MEXP_STB;
          s_next.rd_n = s_reg.wr;
          s_next.wr_n = !s_reg.wr;
          s_next.cnt  = CNT_W'((s_reg.fetch ? FETCH_LOW : STB_LOW) - 1);
        end
      end
      MEXP_STB: begin
        if (s_reg.cnt == '0) begin
          s_next.rd_n  = 1'b1;
          s_next.wr_n  = 1'b1;
          s_next.rdata = ad_s;
          s_next.st    = s_reg.wr ? MEXP_WHOLD : MEXP_DONE;
          s_next.cnt   = CNT_W'(WR_HOLD - 1);
        end
      end
      MEXP_WHOLD: begin
        // Data stays on the bus after the write strobe rises
        if (s_reg.cnt == '0) begin
          s_next.st = MEXP_DONE;
        end
      end
      MEXP_DONE: begin
        s_next.st   = MEXP_IDLE;
        s_next.done = 1'b1;
        s_next.ext  = 1'b1;
        s_next.m1   = 1'b0;
        s_next.iom  = 1'b0;
      end
    endcase

    // Address/data port: address while latched, data only for writes
    if (mode_eff != MODE_NONE && s_reg.st != MEXP_IDLE) begin
      if (s_next.st == MEXP_ADDR || s_next.st == MEXP_HOLD) begin
        s_next.ad_o  = s_reg.st == MEXP_IDLE ? acc_addr[7:0] : s_reg.addr[7:0];
        s_next.ad_oe = 8'hFF;
      end else begin
        s_next.ad_o  = s_reg.wdata;
        s_next.ad_oe = {8{s_reg.wr}};
      end
    end else if (mode_eff != MODE_NONE && s_next.st == MEXP_ADDR) begin
      s_next.ad_o  = acc_addr[7:0];
      s_next.ad_oe = 8'hFF;
    end else if (mode_eff != MODE_NONE) begin
      s_next.ad_o  = s_reg.ad_out;
      s_next.ad_oe = 8'h00;  // Bus idle: port released
    end else begin
      s_next.ad_o  = s_reg.ad_out;
      s_next.ad_oe = {8{s_reg.ad_dir}};
    end
    s_next.ad_rd = ad_s;

    // High port: address lines per mode, general I/O elsewhere
    for (int i = 0; i < 8; i++) begin
      if (hm[i]) begin
        s_next.hi_o[i]  = s_next.st == MEXP_IDLE ? 1'b0 :
                          (s_reg.st == MEXP_IDLE ? acc_addr[8+i] : s_reg.addr[8+i]);
        s_next.hi_oe[i] = 1'b1;
      end else begin
        s_next.hi_o[i]  = s_reg.hi_out[i];
        s_next.hi_oe[i] = s_reg.hi_dir[i];
      end
      s_next.alt_o[i]  = s_reg.alt_func[i] ? alt_periph_out[i] : s_reg.alt_out[i];
      s_next.alt_oe[i] = s_reg.alt_dir[i];
    end
    s_next.hi_rd  = hi_s;
    s_next.alt_rd = alt_s;
    s_next.mode   = mode_of(s_next.bus_en, s_next.strap);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_reg          <= '0;
      s_reg.st       <= MEXP_IDLE;
      s_reg.ad_out   <= RST_BYTE;
      s_reg.rd_n     <= 1'b1;
      s_reg.wr_n     <= 1'b1;
      s_reg.alt_func <= RST_BYTE;
      s_reg.alt_dir  <= RST_BYTE;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign acc_done              = s_reg.done;
  assign acc_ext               = s_reg.ext;
  assign acc_rdata             = s_reg.rdata;
  assign addr_data_rd          = s_reg.ad_rd;
  assign high_rd               = s_reg.hi_rd;
  assign alt_rd                = s_reg.alt_rd;
  assign exp_mode              = s_reg.mode;
  assign addr_data_lines_o     = s_reg.ad_o;
  assign addr_data_lines_oe    = s_reg.ad_oe;
  assign high_address_lines_o  = s_reg.hi_o;
  assign high_address_lines_oe = s_reg.hi_oe;
  assign alt_function_lines_o  = s_reg.alt_o;
  assign alt_function_lines_oe = s_reg.alt_oe;
  // Mode pins turn to outputs once the strap has been caught
  assign mode_select_hi_o      = s_reg.m1;
  assign mode_select_hi_oe     = s_reg.strap_done;
  assign mode_select_lo_o      = s_reg.iom;
  assign mode_select_lo_oe     = s_reg.strap_done;
  assign ale                   = s_reg.ale;
  assign rd_n                  = s_reg.rd_n;
  assign wr_n                  = s_reg.wr_n;
endmodule : mexp_bus
`default_nettype wire

// ==== rtl/mexp_pkg.sv ====
// Package of constants and types for the memory expansion port bus
package mexp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Least address hold after the latch strobe falls, in ns
  localparam int unsigned ADDR_HOLD_NS  = 35;
  localparam int unsigned ADDR_HOLD_CYC = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least latch strobe high width, in ns
  localparam int unsigned ALE_HIGH_NS   = 90;
  localparam int unsigned ALE_HIGH_CYC  = (ALE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least read/write strobe low width for data access, in ns
  localparam int unsigned STB_LOW_NS    = 215;
  localparam int unsigned STB_LOW_CYC   = (STB_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least read strobe low width for opcode fetch, in ns
  localparam int unsigned FETCH_LOW_NS  = 415;
  localparam int unsigned FETCH_LOW_CYC = (FETCH_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least write data hold after write strobe rises, in ns
  localparam int unsigned WR_HOLD_NS    = 60;
  localparam int unsigned WR_HOLD_CYC   = (WR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 6;

  // Internal memory ranges
  localparam logic [15:0] ROM_LAST   = 16'h0FFF;
  localparam logic [15:0] RAM_FIRST  = 16'hFF00;

  // Expansion mode codes
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_256  = 3'h1;
  localparam logic [2:0] MODE_4K   = 3'h2;
  localparam logic [2:0] MODE_16K  = 3'h3;
  localparam logic [2:0] MODE_60K  = 3'h4;

  // Address lines of the high port per mode
  localparam logic [7:0] HI_MASK_4K  = 8'h0F;
  localparam logic [7:0] HI_MASK_16K = 8'h3F;
  localparam logic [7:0] HI_MASK_60K = 8'hFF;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [5:0] {
    MEXP_IDLE  = 6'b00_0001,
    MEXP_ADDR  = 6'b00_0010,
    MEXP_HOLD  = 6'b00_0100,
    MEXP_STB   = 6'b00_1000,
    MEXP_WHOLD = 6'b01_0000,
    MEXP_DONE  = 6'b10_0000
  } mexp_state_e;
endpackage : mexp_pkg

// ==== rtl/mexp_sync.sv ====
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none
module mexp_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : mexp_sync
`default_nettype wire

// ==== verification/mexp_bus_assertions.sv ====
// Checker of strobe order, widths and pin drive of the expansion bus
`timescale 1ns/100ps
`default_nettype none
module mexp_bus_assertions
  import mexp_pkg::*;
#(
  parameter int unsigned ALE_HIGH  = 9,
  parameter int unsigned STB_LOW   = 22,
  parameter int unsigned FETCH_LOW = 42
) (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       acc_req,
  input wire logic       acc_fetch,
  input wire logic       acc_io,
  input wire logic [7:0] addr_data_lines_o,
  input wire logic [7:0] addr_data_lines_oe,
  input wire logic [7:0] high_address_lines_oe,
  input wire logic [2:0] exp_mode,
  input wire logic       mode_select_hi_o,
  input wire logic       mode_select_lo_o,
  input wire logic       ale,
  input wire logic       rd_n,
  input wire logic       wr_n
);
  logic [7:0] ale_run;
  logic [7:0] rd_run;
  logic [7:0] wr_run;
  logic [7:0] hmask;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Run lengths are counted so widths can be checked without long repetitions
  always_ff @(posedge core_clk) begin
    ale_run <= (sys_rst || !ale) ? 8'h00 : ale_run + 8'h01;
    rd_run  <= (sys_rst || rd_n) ? 8'h00 : rd_run + 8'h01;
    wr_run  <= (sys_rst || wr_n) ? 8'h00 : wr_run + 8'h01;
  end
  always_comb begin
    case (exp_mode)
      MODE_4K:  hmask = HI_MASK_4K;
      MODE_16K: hmask = HI_MASK_16K;
      MODE_60K: hmask = HI_MASK_60K;
      default:  hmask = 8'h00;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_rst_idle;
    $fell(sys_rst) |-> rd_n && wr_n && !ale && addr_data_lines_oe == 8'h00;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("strobes not idle after reset");
  property p_one_strobe;
    !(!rd_n && !wr_n);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("read and write strobes both low");
  property p_stb_after_ale;
    $fell(rd_n) || $fell(wr_n) |-> !ale && !$past(ale);
  endproperty
  a_stb_after_ale: assert property (p_stb_after_ale) else $error("strobe overlaps latch strobe");
  property p_ale_width;
    $fell(ale) |-> ale_run == 8'(ALE_HIGH);
  endproperty
  a_ale_width: assert property (p_ale_width) else $error("latch strobe width wrong");
  property p_ale_addr;
    ale && $past(ale) |-> $stable(addr_data_lines_o) && addr_data_lines_oe == 8'hFF;
  endproperty
  a_ale_addr: assert property (p_ale_addr) else $error("low address moved under latch strobe");
  property p_rd_width;
    $rose(rd_n) |-> rd_run == 8'(mode_select_hi_o ? FETCH_LOW : STB_LOW);
  endproperty
  a_rd_width: assert property (p_rd_width) else $error("read strobe width wrong");
  property p_rd_float;
    !rd_n |-> addr_data_lines_oe == 8'h00;
  endproperty
  a_rd_float: assert property (p_rd_float) else $error("bus driven during read");
  property p_wr_width;
    $rose(wr_n) |-> wr_run == 8'(STB_LOW) && addr_data_lines_oe == 8'hFF;
  endproperty
  a_wr_width: assert property (p_wr_width) else $error("write strobe width or data hold wrong");
  property p_ale_cause;
    $rose(ale) |-> $past(acc_req) && (high_address_lines_oe & hmask) == hmask;
  endproperty
  a_ale_cause: assert property (p_ale_cause) else $error("bus cycle without request or high lines");
  property p_markers;
    $rose(ale) |-> mode_select_hi_o == $past(acc_fetch) && mode_select_lo_o == $past(acc_io);
  endproperty
  a_markers: assert property (p_markers) else $error("fetch or io marker wrong");
endmodule : mexp_bus_assertions
bind mexp_bus mexp_bus_assertions #(.ALE_HIGH(ALE_HIGH), .STB_LOW(STB_LOW), .FETCH_LOW(FETCH_LOW)) chk_u (
  .core_clk, .sys_rst, .acc_req, .acc_fetch, .acc_io, .addr_data_lines_o, .addr_data_lines_oe,
  .high_address_lines_oe, .exp_mode, .mode_select_hi_o, .mode_select_lo_o, .ale, .rd_n, .wr_n);
`default_nettype wire

// ==== verification/mexp_bus_test.sv ====
// Self-checking bench of the memory expansion port bus
`timescale 1ns/100ps
`default_nettype none
module mexp_bus_test;
  import mexp_pkg::*;
  typedef struct packed {logic [1:0] s; logic [2:0] md; logic [7:0] mk; logic [15:0] oor;} mexp_row_s;
  logic        core_clk, sys_rst, clk_en, acc_req, acc_write, acc_fetch, acc_io, acc_done, acc_ext;
  logic        cfg_we, bus_en_in, addr_data_dir_in, port_we, ale, rd_n, wr_n;
  logic        mode_select_hi_o, mode_select_hi_oe, mode_select_lo_o, mode_select_lo_oe;
  logic [15:0] acc_addr;
  logic [7:0]  acc_wdata, acc_rdata, high_dir_in, alt_dir_in, alt_func_in, addr_data_out_in, high_out_in;
  logic [7:0]  alt_out_in, alt_periph_out, addr_data_rd, high_rd, alt_rd, addr_data_lines_o, addr_data_lines_oe;
  logic [7:0]  high_address_lines_i, high_address_lines_o, high_address_lines_oe, alt_function_lines_i;
  logic [7:0]  alt_function_lines_o, alt_function_lines_oe, ad_drv, m;
  logic [2:0]  exp_mode;
  logic [1:0]  strap;
  int          mismatches, check_count;
  mexp_row_s   rows [4] = '{'{2'b00, MODE_256, 8'h00, 16'hFF80}, '{2'b01, MODE_4K, HI_MASK_4K, 16'h2000},
                            '{2'b10, MODE_16K, HI_MASK_16K, 16'h5000}, '{2'b11, MODE_60K, HI_MASK_60K, 16'h0FFF}};
  wire logic [7:0] addr_data_lines_i = (addr_data_lines_oe & addr_data_lines_o) | (~addr_data_lines_oe & ad_drv);
  wire logic mode_select_hi_i = mode_select_hi_oe ? mode_select_hi_o : strap[1];
  wire logic mode_select_lo_i = mode_select_lo_oe ? mode_select_lo_o : strap[0];
  // Short counts keep the run brief; the checker gets the latch and strobe widths through the bind
  mexp_bus #(.ADDR_HOLD(1), .ALE_HIGH(2), .STB_LOW(3), .FETCH_LOW(4), .WR_HOLD(1)) dut_u (
    .core_clk, .sys_rst, .clk_en, .acc_req, .acc_write, .acc_fetch, .acc_io, .acc_addr, .acc_wdata, .acc_done,
    .acc_ext, .acc_rdata, .cfg_we, .bus_en_in, .addr_data_dir_in, .high_dir_in, .alt_dir_in, .alt_func_in,
    .port_we, .addr_data_out_in, .high_out_in, .alt_out_in, .alt_periph_out, .addr_data_rd, .high_rd, .alt_rd,
    .exp_mode, .addr_data_lines_i, .addr_data_lines_o, .addr_data_lines_oe, .high_address_lines_i,
    .high_address_lines_o, .high_address_lines_oe, .alt_function_lines_i, .alt_function_lines_o,
    .alt_function_lines_oe, .mode_select_hi_i, .mode_select_hi_o, .mode_select_hi_oe, .mode_select_lo_i,
    .mode_select_lo_o, .mode_select_lo_oe, .ale, .rd_n, .wr_n);
  mexp_ext_mem mem_u (.core_clk, .ale, .rd_n, .wr_n, .ad_o(addr_data_lines_i), .ad_drv);
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rst(input logic [1:0] s);
    strap <= s;
    sys_rst <= 1'b1;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : rst
  task automatic cfg(input logic en, input logic add, input logic [7:0] hd, input logic [7:0] ad,
                     input logic [7:0] af);
    bus_en_in <= en;
    addr_data_dir_in <= add;
    high_dir_in <= hd;
    alt_dir_in <= ad;
    alt_func_in <= af;
    cfg_we <= 1'b1;
    @(posedge core_clk);
    cfg_we <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : cfg
  // Values are read at the edge, before that edge's updates land
  task automatic acc(input logic w, input logic f, input logic io, input logic [15:0] a, input logic [7:0] d);
    int n;
    acc_req <= 1'b1;
    acc_write <= w;
    acc_fetch <= f;
    acc_io <= io;
    acc_addr <= a;
    acc_wdata <= d;
    @(posedge core_clk);
    acc_req <= 1'b0;
    n = 0;
    while (acc_done !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
      if (ale === 1'b1) begin
        chk(addr_data_lines_o, a[7:0]);
        chk({high_address_lines_o & m, high_address_lines_oe}, {a[15:8] & m, m});
        chk({mode_select_hi_o, mode_select_lo_o}, {f, io});
      end
    end
    chk(n < 200, 1'b1);
  endtask : acc
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #50us;
    mismatches++;
    print_verdict();
  end
  initial begin
    {sys_rst, clk_en} = 2'b11;
    {acc_req, acc_write, acc_fetch, acc_io, acc_addr, acc_wdata, cfg_we, bus_en_in, addr_data_dir_in} = '0;
    {high_dir_in, alt_dir_in, alt_func_in, port_we, addr_data_out_in, high_out_in, alt_out_in} = '0;
    {alt_periph_out, high_address_lines_i, alt_function_lines_i, strap, m, mismatches, check_count} = '0;
    foreach (rows[i]) begin
      rst(rows[i].s);
      m = rows[i].mk;
      chk({addr_data_lines_oe, high_address_lines_oe}, 16'h0000);
      chk({alt_function_lines_oe, 5'h00, rd_n, wr_n, ale}, 16'h0006);
      chk(exp_mode, MODE_NONE);
      chk({mode_select_hi_oe, mode_select_lo_oe, mode_select_hi_o, mode_select_lo_o}, 4'hC);
      cfg(1'b1, 1'b0, 8'h00, 8'h00, 8'h00);
      chk(exp_mode, rows[i].md);
      acc(1'b1, 1'b0, 1'b1, 16'h10a5, 8'h5A + 8'(i));
      acc(1'b0, 1'b1, 1'b0, 16'h10a5, 8'h00);
      chk({acc_ext, acc_rdata}, {1'b1, 8'h5A + 8'(i)});
      acc(1'b0, 1'b0, 1'b0, rows[i].oor, 8'h00);
      chk(acc_ext, 1'b0);
    end
    foreach (rows[i]) begin
      acc(1'b0, 1'b0, 1'b0, 16'hFF00 - 16'(i), 8'h00);
      chk(acc_ext, i != 0);
    end
    $display("test expansion modes done");
    rst(2'b00);
    high_address_lines_i <= 8'h5A;
    alt_function_lines_i <= 8'hC3;
    cfg(1'b0, 1'b1, 8'hA5, 8'h3C, 8'h0C);
    addr_data_out_in <= 8'h96;
    high_out_in <= 8'h69;
    alt_out_in <= 8'hF0;
    alt_periph_out <= 8'h04;
    port_we <= 1'b1;
    @(posedge core_clk);
    port_we <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk(addr_data_rd, 8'h96);
    chk({addr_data_lines_oe, addr_data_lines_o}, 16'hFF96);
    chk({high_address_lines_oe, high_address_lines_o & 8'hA5}, 16'hA521);
    chk({alt_function_lines_oe & 8'hF3, alt_function_lines_o & 8'h3C}, 16'h3034);
    chk({high_rd & 8'h5A, alt_rd & 8'hC3}, 16'h5AC3);
    $display("test general ports done");
    cfg(1'b1, 1'b0, 8'hA5, 8'h3C, 8'h0C);
    acc_req <= 1'b1;
    acc_addr <= 16'h1034;
    @(posedge core_clk);
    acc_req <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(rd_n, 1'b0);
    // Clock enable low must freeze the strobe mid-cycle
    clk_en <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk({rd_n, acc_done}, 2'b00);
    clk_en <= 1'b1;
    rst(2'b11);
    chk({high_address_lines_oe, alt_function_lines_oe}, 16'h0000);
    chk({exp_mode, rd_n, wr_n, ale}, {MODE_NONE, 3'b110});
    $display("test reset in mid cycle done");
    print_verdict();
  end
endmodule : mexp_bus_test
`default_nettype wire

// ==== verification/mexp_ext_mem.sv ====
// Behavioural external memory on the multiplexed bus
`timescale 1ns/100ps
`default_nettype none
module mexp_ext_mem (
  input  wire logic       core_clk,
  input  wire logic       ale,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [7:0] ad_o,
  output var  logic [7:0] ad_drv
);
  logic [7:0] mem [256];
  logic [7:0] lat;
  logic [1:0] hold;
  logic       wr_q;
  initial begin
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'hC3;
    ad_drv = 8'h00;
    hold = 2'd0;
    wr_q = 1'b1;
  end
  // Released bus toggles so a late sample matches by luck only on every other cycle
  always @(posedge core_clk) begin
    wr_q <= wr_n;
    if (ale) lat <= ad_o;
    if (!wr_q && wr_n) mem[lat] <= ad_o;
    if (!rd_n) begin
      ad_drv <= mem[lat];
      hold <= 2'd2;
    end else if (hold != 2'd0) begin
      hold <= hold - 2'd1;
    end else begin
      ad_drv <= ~ad_drv;
    end
  end
endmodule : mexp_ext_mem
`default_nettype wire
